// ### shared/cbt_map.svh
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// register indices; the byte address is four times the index
`define CBT_IDX_IE        16'hff96
`define CBT_IDX_INTS      16'hff98
`define CBT_IDX_BRP       16'hff9a
`define CBT_IDX_BTR       16'hff9c
`define CBT_IDX_CTRL      16'hff9e

// enable register write layout
`define CBT_IE_SET_LSB    8
`define CBT_IE_CLR_LSB    0
`define CBT_NUM_SRC       6

// status bit positions
`define CBT_EV_TX_DONE    0
`define CBT_EV_RX_VALID   1
`define CBT_EV_ERR_STATE  2
`define CBT_EV_PROTO_ERR  3
`define CBT_EV_ARB_LOSS   4
`define CBT_EV_WAKEUP     5

// bit timing register layout
`define CBT_BTR_SEG1_LSB  0
`define CBT_BTR_SEG2_LSB  8
`define CBT_BTR_SJW_LSB   12

// control register layout
`define CBT_CTRL_INIT     0
`define CBT_CTRL_PH_LSB   4

// reset values
`define CBT_RST_IE        6'h00
`define CBT_RST_INTS      6'h00
`define CBT_RST_BRP       8'hff
`define CBT_RST_SEG1      4'hf
`define CBT_RST_SEG2      3'h7
`define CBT_RST_SJW       2'h3
`define CBT_RST_INIT      1'b1

`endif

// ### shared/cbt_pkg.sv
package cbt_pkg;

    typedef enum logic [3:0] {
        CBT_PH_IDLE = 4'b0001,
        CBT_PH_SYNC = 4'b0010,
        CBT_PH_SEG1 = 4'b0100,
        CBT_PH_SEG2 = 4'b1000
    } cbt_phase_type;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } cbt_div_state_type;

    typedef struct packed {
        logic [5:0]    ie;
        logic [5:0]    ints;
        logic [7:0]    brp;
        logic [3:0]    seg1;
        logic [2:0]    seg2;
        logic [1:0]    sjw;
        logic          init;
        cbt_phase_type phase;
        logic [3:0]    tq_cnt;
        logic          sample;
        logic          bit_start;
        logic          tq_out;
        logic          irq;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } cbt_state_type;

endpackage : cbt_pkg

// ### verilog/cbt_qdiv.sv
`timescale 1ns/1ns
`default_nettype none

// time quantum divider: one enable pulse every (divider + 1) module clocks
module cbt_qdiv (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // control
    input  wire logic       run,
    input  wire logic [7:0] quantum_divider,
    // quantum enable
    output logic            quantum_clock
);

    cbt_pkg::cbt_div_state_type state_ff;
    cbt_pkg::cbt_div_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (!run) begin
            // restart aligned so the first quantum after leaving init is full length
            nxt_state.count = quantum_divider;
        end else if (state_ff.count == 8'h00) begin
            nxt_state.count = quantum_divider;
            nxt_state.tick  = 1'b1;
        end else begin
            nxt_state.count = state_ff.count - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '{count: 8'hff, tick: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign quantum_clock = state_ff.tick;

endmodule : cbt_qdiv

`default_nettype wire

// ### verilog/cbt_top.sv
// Functional notes
// - enable bit sets on set=1/clear=0, clears on set=0/clear=1, else holds
// - set controls at write bits 8..13, clear controls at bits 0..5
// - each enable bit gates the interrupt of its matching status bit
// - enable register is 16 bits and resets to zero
// - status bit reads 1 while its source event is pending
// - status bits: 5 wakeup, 4 arb loss, 3 proto err, 2 err state, 1 rx, 0 tx
// - wakeup status set only by bus wakeup, never by software sleep release
// - writing 1 to a status position clears it, 0 leaves it
// - status bits never clear by themselves; software clears them
// - status register is 16 bits and resets to zero
// - quantum clock is module clock divided by prescaler plus one, default 256
// - prescaler is writable only in initialization mode
// - jump width field gives value plus one quanta, default 4
// - second segment field gives value plus one quanta, default 8
// - first segment field gives value plus one quanta, default 16, zero prohibited
// - one quantum is one quantum clock period; fields set the bit length
`timescale 1ns/1ns
`default_nettype none

`include "cbt_map.svh"

module cbt_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt event pulses from the protocol engine
    input  wire logic        ev_tx_done,
    input  wire logic        ev_rx_valid,
    input  wire logic        ev_err_state,
    input  wire logic        ev_proto_err,
    input  wire logic        ev_arb_loss,
    input  wire logic        ev_bus_wakeup,
    // interrupt
    output logic             irq,
    // bit timing to the protocol engine
    output logic             quantum_clock,
    output logic             sample_point,
    output logic             bit_start,
    output logic [1:0]       resync_jump_width
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    cbt_pkg::cbt_state_type state_ff;
    cbt_pkg::cbt_state_type nxt_state;

    logic        tq_tick;
    logic [5:0]  ev_vec;
    logic [5:0]  ie_next;
    logic [15:0] wr_mask;
    logic [15:0] wdata;
    logic [15:0] idx;
    logic        setup;
    logic        wr_en;
    logic        hit_ie;
    logic        hit_ints;
    logic        hit_brp;
    logic        hit_btr;
    logic        hit_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // quantum divider

    cbt_qdiv u_qdiv (
        .clock           (clock),
        .nrst            (nrst),
        .run             (~state_ff.init),
        .quantum_divider (state_ff.brp),
        .quantum_clock   (tq_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign idx      = paddr[17:2];
    assign setup    = psel & ~penable;
    // a write lands only at the completing edge of the access phase
    assign wr_en    = psel & penable & pwrite & state_ff.pready;
    assign wr_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata    = pwdata[15:0] & wr_mask;
    assign hit_ie   = (idx == `CBT_IDX_IE);
    assign hit_ints = (idx == `CBT_IDX_INTS);
    assign hit_brp  = (idx == `CBT_IDX_BRP);
    assign hit_btr  = (idx == `CBT_IDX_BTR);
    assign hit_ctrl = (idx == `CBT_IDX_CTRL);

    // wakeup input is driven only by bus activity, so software release never sets it
    assign ev_vec[`CBT_EV_TX_DONE]   = ev_tx_done;
    assign ev_vec[`CBT_EV_RX_VALID]  = ev_rx_valid;
    assign ev_vec[`CBT_EV_ERR_STATE] = ev_err_state;
    assign ev_vec[`CBT_EV_PROTO_ERR] = ev_proto_err;
    assign ev_vec[`CBT_EV_ARB_LOSS]  = ev_arb_loss;
    assign ev_vec[`CBT_EV_WAKEUP]    = ev_bus_wakeup;

    ////////////////////////////////////////////////////////////////////////////
    // enable bits: set/clear pairs

    genvar gi;
    generate
        for (gi = 0; gi < `CBT_NUM_SRC; gi = gi + 1) begin : g_ie
            logic set_b;
            logic clr_b;
            assign set_b = wdata[`CBT_IE_SET_LSB + gi];
            assign clr_b = wdata[`CBT_IE_CLR_LSB + gi];
            always_comb begin
                ie_next[gi] = state_ff.ie[gi];
                if (wr_en && hit_ie) begin
                    if (set_b && !clr_b) begin
                        ie_next[gi] = 1'b1;
                    end else if (!set_b && clr_b) begin
                        ie_next[gi] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_state           = state_ff;
        nxt_state.sample    = 1'b0;
        nxt_state.bit_start = 1'b0;
        nxt_state.tq_out    = tq_tick;
        nxt_state.ie        = ie_next;

        // status: an event in the clearing cycle survives the clear
        if (wr_en && hit_ints) begin
            nxt_state.ints = state_ff.ints & ~wdata[5:0];
        end
        nxt_state.ints = nxt_state.ints | ev_vec;

        // prescaler locked outside initialization mode
        if (wr_en && hit_brp && state_ff.init && pstrb[0]) begin
            nxt_state.brp = pwdata[7:0];
        end

        // no guard on a zero first segment or short segment with prescaler zero:
        // software keeps those settings out
        if (wr_en && hit_btr) begin
            if (pstrb[0]) begin
                nxt_state.seg1 = pwdata[`CBT_BTR_SEG1_LSB +: 4];
            end
            if (pstrb[1]) begin
                nxt_state.seg2 = pwdata[`CBT_BTR_SEG2_LSB +: 3];
                nxt_state.sjw  = pwdata[`CBT_BTR_SJW_LSB +: 2];
            end
        end

        if (wr_en && hit_ctrl && pstrb[0]) begin
            nxt_state.init = pwdata[`CBT_CTRL_INIT];
        end

        // interrupt line follows registered status and enables
        nxt_state.irq = |(nxt_state.ints & nxt_state.ie);

        // bit timing sequencer
        case (state_ff.phase)
            cbt_pkg::CBT_PH_IDLE: begin
                nxt_state.tq_cnt = 4'h0;
                if (!state_ff.init) begin
                    nxt_state.phase = cbt_pkg::CBT_PH_SYNC;
                end
            end
            cbt_pkg::CBT_PH_SYNC: begin
                if (tq_tick) begin
                    // sync segment is always exactly one quantum
                    nxt_state.phase  = cbt_pkg::CBT_PH_SEG1;
                    nxt_state.tq_cnt = 4'h0;
                end
            end
            cbt_pkg::CBT_PH_SEG1: begin
                if (tq_tick) begin
                    if (state_ff.tq_cnt == state_ff.seg1) begin
                        nxt_state.phase  = cbt_pkg::CBT_PH_SEG2;
                        nxt_state.tq_cnt = 4'h0;
                        nxt_state.sample = 1'b1;
                    end else begin
                        nxt_state.tq_cnt = state_ff.tq_cnt + 4'h1;
                    end
                end
            end
            cbt_pkg::CBT_PH_SEG2: begin
                if (tq_tick) begin
                    if (state_ff.tq_cnt == {1'b0, state_ff.seg2}) begin
                        nxt_state.phase     = cbt_pkg::CBT_PH_SYNC;
                        nxt_state.tq_cnt    = 4'h0;
                        nxt_state.bit_start = 1'b1;
                    end else begin
                        nxt_state.tq_cnt = state_ff.tq_cnt + 4'h1;
                    end
                end
            end
            default: begin
                nxt_state.phase  = cbt_pkg::CBT_PH_IDLE;
                nxt_state.tq_cnt = 4'h0;
            end
        endcase
        // entering init aborts the bit at once
        if (state_ff.init) begin
            nxt_state.phase  = cbt_pkg::CBT_PH_IDLE;
            nxt_state.tq_cnt = 4'h0;
        end

        // apb: read data captured in setup, one wait-free access phase
        nxt_state.pready  = setup;
        nxt_state.pslverr = 1'b0;
        nxt_state.prdata  = 32'h0000_0000;
        if (setup) begin
            nxt_state.pslverr = ~(hit_ie | hit_ints | hit_brp | hit_btr | hit_ctrl);
            if (hit_ie) begin
                nxt_state.prdata[5:0] = state_ff.ie;
            end
            if (hit_ints) begin
                nxt_state.prdata[5:0] = state_ff.ints;
            end
            if (hit_brp) begin
                nxt_state.prdata[7:0] = state_ff.brp;
            end
            if (hit_btr) begin
                nxt_state.prdata[`CBT_BTR_SEG1_LSB +: 4] = state_ff.seg1;
                nxt_state.prdata[`CBT_BTR_SEG2_LSB +: 3] = state_ff.seg2;
                nxt_state.prdata[`CBT_BTR_SJW_LSB +: 2]  = state_ff.sjw;
            end
            if (hit_ctrl) begin
                nxt_state.prdata[`CBT_CTRL_INIT]       = state_ff.init;
                nxt_state.prdata[`CBT_CTRL_PH_LSB +: 4] = state_ff.phase;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff.ie        <= `CBT_RST_IE;
            state_ff.ints      <= `CBT_RST_INTS;
            state_ff.brp       <= `CBT_RST_BRP;
            state_ff.seg1      <= `CBT_RST_SEG1;
            state_ff.seg2      <= `CBT_RST_SEG2;
            state_ff.sjw       <= `CBT_RST_SJW;
            state_ff.init      <= `CBT_RST_INIT;
            state_ff.phase     <= cbt_pkg::CBT_PH_IDLE;
            state_ff.tq_cnt    <= 4'h0;
            state_ff.sample    <= 1'b0;
            state_ff.bit_start <= 1'b0;
            state_ff.tq_out    <= 1'b0;
            state_ff.irq       <= 1'b0;
            state_ff.pready    <= 1'b0;
            state_ff.pslverr   <= 1'b0;
            state_ff.prdata    <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata            = state_ff.prdata;
    assign pready            = state_ff.pready;
    assign pslverr           = state_ff.pslverr;
    assign irq               = state_ff.irq;
    assign quantum_clock     = state_ff.tq_out;
    assign sample_point      = state_ff.sample;
    assign bit_start         = state_ff.bit_start;
    assign resync_jump_width = state_ff.sjw;

endmodule : cbt_top

`default_nettype wire

// ### dv/cbt_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // interrupt and timing
    input wire logic        irq,
    input wire logic        quantum_clock,
    input wire logic        sample_point,
    input wire logic        bit_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_answer)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_rdata_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("read data above bit 15");
    // status never drops by itself, so irq only falls after a write
    a_irq_fall_write: assert property ($fell(irq) |-> $past(pready && pwrite))
        else $error("irq fell without a write");
    // phase pulses are launched by the same divider tick as the quantum pulse
    a_sample_on_tick: assert property (sample_point |-> quantum_clock)
        else $error("sample point off the quantum");
    a_start_on_tick: assert property (bit_start |-> quantum_clock)
        else $error("bit start off the quantum");
    // second segment is at least one quantum, a whole bit at least four
    a_seg_two_gap: assert property (sample_point |-> !bit_start ##1 (!sample_point) [*3])
        else $error("second segment too short");
    a_bit_min_len: assert property (bit_start |=> (!bit_start) [*3])
        else $error("bit shorter than four quanta");
endmodule : cbt_checker
bind cbt_top cbt_checker chk_i (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .quantum_clock(quantum_clock), .sample_point(sample_point), .bit_start(bit_start)
);
`default_nettype wire

// ### dv/cbt_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_engine_model (
    // clock and reset
    input wire logic   clock,
    input wire logic   nrst,
    // timing from the block
    input wire logic   sample_point,
    input wire logic   bit_start,
    // event requests from the bench
    input wire logic [5:0] fire,
    output logic [5:0] ev,
    // measured bit
    output logic [15:0] bit_len,
    output logic [15:0] tail_len,
    output logic        len_valid
);
    logic [15:0] cnt, tcnt;
    logic        seen;
    // wakeup only when the bench commands bus activity, never on software release
    assign ev = fire;
    // the first bit after leaving init is not measured: its start is unknown
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {cnt, tcnt, seen, len_valid, bit_len, tail_len} <= '0;
        end else begin
            cnt <= cnt + 16'h0001;
            tcnt <= tcnt + 16'h0001;
            len_valid <= 1'b0;
            if (sample_point) tcnt <= 16'h0001;
            if (bit_start) begin
                cnt <= 16'h0001;
                bit_len <= cnt;
                tail_len <= tcnt;
                len_valid <= seen;
                seen <= 1'b1;
            end
        end
    end
endmodule : cbt_engine_model
`default_nettype wire

// ### dv/cbt_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbt_map.svh"
module cbt_top_test;
    logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, irq, quantum_clock, sample_point, bit_start, len_valid;
    logic [1:0]  resync_jump_width;
    logic [5:0]  ev, fire = 0, iem;
    logic [15:0] bit_len, tail_len;
    logic [33:0] q;
    logic [33:0] rdq[$];
    logic [31:0] bitq[$];
    int          n_mismatch = 0, total_checks = 0, cyc = 0, seed = 61, i, qgap = 0;
    always #4 clock = ~clock;
    cbt_top uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ev_tx_done(ev[0]), .ev_rx_valid(ev[1]), .ev_err_state(ev[2]),
        .ev_proto_err(ev[3]), .ev_arb_loss(ev[4]), .ev_bus_wakeup(ev[5]), .irq(irq),
        .quantum_clock(quantum_clock), .sample_point(sample_point), .bit_start(bit_start),
        .resync_jump_width(resync_jump_width));
    cbt_engine_model far_i (.clock(clock), .nrst(nrst), .sample_point(sample_point),
        .bit_start(bit_start), .fire(fire), .ev(ev), .bit_len(bit_len), .tail_len(tail_len),
        .len_valid(len_valid));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic xfer(input logic w, input logic [15:0] ix, input logic [31:0] d,
                        input logic [31:0] e, input logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        rdq.push_back({!w, err, e});
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic fire_ev(input logic [5:0] p);
        @(posedge clock);
        fire <= p;
        @(posedge clock);
        fire <= 6'h00;
    endtask : fire_ev
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clock);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report;
        end
    end
    always @(posedge clock) begin
        if (pready && psel && penable) begin
            q = rdq.pop_front();
            if (q[33]) chk("prdata", q[31:0], prdata);
            chk("pslverr", {31'h0, q[32]}, {31'h0, pslverr});
        end
        if (len_valid && bitq.size() > 0) begin
            chk("bit and tail", bitq.pop_front(), {bit_len, tail_len});
        end
        // prescaler 1 is the only running setting, so quanta are 1 + 1 clocks apart
        if (quantum_clock) begin
            if (qgap > 0) chk("quantum gap", 32'd2, qgap);
            qgap = 1;
        end else if (qgap > 0) begin
            qgap++;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        xfer(0, `CBT_IDX_IE, 0, 32'h0000_0000, 0);
        xfer(0, `CBT_IDX_INTS, 0, 32'h0000_0000, 0);
        xfer(0, `CBT_IDX_BRP, 0, 32'h0000_00ff, 0);
        xfer(0, `CBT_IDX_BTR, 0, 32'h0000_370f, 0);
        xfer(0, 16'hffa0, 0, 32'h0000_0000, 1);
        xfer(1, 16'hffa0, 32'h0000_ffff, 0, 1);
        chk("jump width", 32'h3, {30'h0, resync_jump_width});
        xfer(1, `CBT_IDX_IE, 32'h0000_3f00, 0, 0);
        iem = 6'h3f;
        for (i = 0; i < 6; i++) begin
            r = $random(seed) & 32'h0000_3f3f;
            xfer(1, `CBT_IDX_IE, r, 0, 0);
            iem = (iem & ~(r[5:0] & ~r[13:8])) | (r[13:8] & ~r[5:0]);
            xfer(0, `CBT_IDX_IE, 0, {26'h0, iem}, 0);
        end
        // with every source masked the pending bits must stay invisible on irq
        xfer(1, `CBT_IDX_IE, 32'h0000_003f, 0, 0);
        fire_ev(6'h3f);
        chk_irq(1'b0);
        xfer(0, `CBT_IDX_INTS, 0, 32'h0000_003f, 0);
        xfer(1, `CBT_IDX_INTS, 32'h0000_0000, 0, 0);
        xfer(0, `CBT_IDX_INTS, 0, 32'h0000_003f, 0);
        r = $random(seed);
        xfer(1, `CBT_IDX_INTS, r & 32'h0000_003f, 0, 0);
        xfer(0, `CBT_IDX_INTS, 0, {26'h0, ~r[5:0]}, 0);
        xfer(1, `CBT_IDX_INTS, 32'h0000_003f, 0, 0);
        xfer(1, `CBT_IDX_IE, 32'h0000_3f00, 0, 0);
        for (i = 0; i < 6; i++) begin
            fire_ev(6'h01 << i);
            chk_irq(1'b1);
            xfer(0, `CBT_IDX_INTS, 0, 32'h0000_0001 << i, 0);
            xfer(1, `CBT_IDX_INTS, 32'h0000_0001 << i, 0, 0);
            chk_irq(1'b0);
        end
        // prescaler 1 avoids the short second segment that prescaler 0 forbids
        xfer(1, `CBT_IDX_BRP, 32'h0000_0001, 0, 0);
        xfer(1, `CBT_IDX_BTR, 32'h0000_1103, 0, 0);
        xfer(0, `CBT_IDX_BTR, 0, 32'h0000_1103, 0);
        bitq.push_back({16'd14, 16'd4});
        bitq.push_back({16'd14, 16'd4});
        xfer(1, `CBT_IDX_CTRL, 32'h0000_0000, 0, 0);
        chk("jump width", 32'h1, {30'h0, resync_jump_width});
        xfer(1, `CBT_IDX_BRP, 32'h0000_0005, 0, 0);
        xfer(0, `CBT_IDX_BRP, 0, 32'h0000_0001, 0);
        xfer(0, `CBT_IDX_INTS, 0, 32'h0000_0000, 0);
        for (i = 0; i < 300 && bitq.size() > 0; i++) @(posedge clock);
        chk("bits left", 32'h0, bitq.size());
        xfer(1, `CBT_IDX_CTRL, 32'h0000_0001, 0, 0);
        final_report;
    end
endmodule : cbt_top_test
`default_nettype wire
